// *** hw/eeprom_pkg.sv ***
package eeprom_pkg;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W     = 17;
  localparam int GRP_IDX_W  = ADDR_W - 2;
  localparam int GRP_BYTES  = 4;
  localparam int PAGE_BYTES = 256;
  localparam int PAGE_GRPS  = PAGE_BYTES / GRP_BYTES;
  localparam int DATA_W     = 32;
  localparam int CHK_W      = 6;
  localparam int ID_LEN     = 3;

  // ----------------------------------------------------------------
  // Select byte and instruction fields
  // ----------------------------------------------------------------
  localparam logic [3:0] TYPE_MEM      = 4'hA;
  localparam logic [3:0] TYPE_ID       = 4'hB;
  localparam int         SEL_RW_BIT    = 0;
  localparam int         SEL_A16_BIT   = 1;
  localparam int         LOCK_ADDR_BIT = 10;
  localparam int         LOCK_DATA_BIT = 1;
  localparam logic [7:0] ERASED_BYTE   = 8'hFF;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ   = 25;
  localparam int TW_US     = 5000;
  localparam int TW_CYCLES = TW_US * CLK_MHZ;
  localparam int TW_W      = 20;

  // Sync reset values, order {wc, threshold, sda, scl}
  localparam logic [3:0] SYNC_RST = 4'h3;

  typedef enum logic [3:0] {
    S_IDLE  = 4'b0000,
    S_SEL   = 4'b0001,
    S_AHI   = 4'b0010,
    S_ALO   = 4'b0011,
    S_WDAT  = 4'b0100,
    S_ACK   = 4'b0101,
    S_RDAT  = 4'b0110,
    S_MACK  = 4'b0111,
    S_WRITE = 4'b1000
  } bus_state_t;

  typedef struct packed {
    bus_state_t          st;
    bus_state_t          after;
    logic [3:0]          bits;
    logic [7:0]          sh;
    logic [ADDR_W-1:0]   addr;
    logic                is_id;
    logic                oe_n;
    logic                pend;
    logic                lock_req;
    logic [TW_W-1:0]     tw;
  } ctl_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [CHK_W-1:0]  chk;
  } codeword_t;

  // Hamming position of data bit i (skips power-of-two slots)
  function automatic logic [CHK_W-1:0] ecc_pos(input int i);
    int p;
    p = 3;
    for (int k = 0; k < DATA_W; k++) begin
      if ((p & (p - 1)) == 0) begin
        p = p + 1;
      end
      if (k == i) begin
        return CHK_W'(p);
      end
      p = p + 1;
    end
    return '0;
  endfunction

  function automatic logic [CHK_W-1:0] ecc_check(input logic [DATA_W-1:0] d);
    logic [CHK_W-1:0] c;
    c = '0;
    for (int i = 0; i < DATA_W; i++) begin
      if (d[i]) begin
        c = c ^ ecc_pos(i);
      end
    end
    return c;
  endfunction

endpackage

// *** hw/ecc_fix.sv ***
`timescale 1ns/1ps
module ecc_fix
  import eeprom_pkg::*;
(
  input  codeword_t         cw,
  output logic [DATA_W-1:0] data_fix,
  output logic              err
);

  logic [CHK_W-1:0] syn;

  // ----------------------------------------------------------------
  // Syndrome and single-bit repair
  // ----------------------------------------------------------------
  always_comb begin
    syn      = ecc_check(cw.data) ^ cw.chk;
    err      = (syn != '0);
    data_fix = cw.data;
    for (int i = 0; i < DATA_W; i++) begin
      if (syn == ecc_pos(i)) begin
        data_fix[i] = ~cw.data[i];
      end
    end
  end

endmodule

// *** hw/eeprom_core.sv ***
`timescale 1ns/1ps
// Summary of operation
// - Below the supply threshold every bus instruction is ignored.
// - Crossing the threshold resets the logic into standby, deselected.
// - Correction happens inside, the bus protocol is unchanged by it.
// - Each four-byte array group is one codeword and array reads return single-bit corrected data.
// - Groups start at byte addresses that are multiples of four.
// - Writing part of a group rewrites the whole group with a consistent codeword.
// - A group is programmed once per write cycle, sharing one endurance budget.
// - Delivered array bytes all read as FFh.
// - Delivered identification page holds the identity code in its first three bytes.
// - Byte, page, identification write and lock instructions start a write cycle.
// - The device deselects after power-up, after a read stop and after a write cycle.
// - The identification page uses its own device type, distinct from the array.
module eeprom_core
  import eeprom_pkg::*;
#(
  parameter logic [1:0]  CHIP_ADDR = 2'h0,
  parameter logic [23:0] ID_CODE   = 24'h123456,  // Arbitrary identity value
  parameter int          TW_CYC    = TW_CYCLES
)(
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic reset_threshold_level,
  input  wire logic write_ctrl,
  input  wire logic scl,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe_n,
  output logic      standby
);

  initial begin
    if (TW_CYC <= PAGE_GRPS || TW_CYC >= (1 << TW_W)) begin
      $error("TW_CYC out of range");
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] s1_reg, s2_reg, s3_reg, flt_reg, pv_reg;
  logic [3:0] flt_next;

  always_comb begin
    flt_next = ((s2_reg ~^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & flt_reg);
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s1_reg  <= SYNC_RST;
      s2_reg  <= SYNC_RST;
      s3_reg  <= SYNC_RST;
      flt_reg <= SYNC_RST;
      pv_reg  <= SYNC_RST;
    end else begin
      s1_reg  <= {write_ctrl, reset_threshold_level, sda_in, scl};
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      flt_reg <= flt_next;
      pv_reg  <= flt_reg;
    end
  end

  logic scl_f, sda_f, thr_f, wc_f;
  logic scl_rise, scl_fall, start_c, stop_c;
  assign {wc_f, thr_f, sda_f, scl_f} = flt_reg;
  assign scl_rise = scl_f & ~pv_reg[0];
  assign scl_fall = ~scl_f & pv_reg[0];
  assign start_c  = scl_f & pv_reg[0] & pv_reg[1] & ~sda_f;
  assign stop_c   = scl_f & pv_reg[0] & ~pv_reg[1] & sda_f;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  codeword_t   mem [2**GRP_IDX_W];
  logic [7:0]  idmem [PAGE_BYTES];
  logic [7:0]  pbuf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] mask_reg, mask_next;
  logic        locked;

  initial begin
    for (int i = 0; i < 2**GRP_IDX_W; i++) begin
      mem[i] = {{GRP_BYTES{ERASED_BYTE}}, ecc_check({GRP_BYTES{ERASED_BYTE}})};
    end
    for (int i = 0; i < PAGE_BYTES; i++) begin
      idmem[i] = (i < ID_LEN) ? ID_CODE[8*(ID_LEN-1-i) +: 8] : ERASED_BYTE;
    end
    locked = 1'b0;
  end

  ctl_t c, n;
  logic [GRP_IDX_W-1:0] rd_idx;
  logic [DATA_W-1:0]    old_fix, merged;
  logic                 ecc_err, walk_we, wr_ok, byte_wr;
  logic [5:0]           grp;
  logic [7:0]           rbyte;

  assign grp    = c.tw[5:0];
  assign rd_idx = (c.st == S_WRITE) ? {c.addr[ADDR_W-1:8], grp} : c.addr[ADDR_W-1:2];

  ecc_fix u_fix (
    .cw       (mem[rd_idx]),
    .data_fix (old_fix),
    .err      (ecc_err)
  );

  always_comb begin
    for (int b = 0; b < GRP_BYTES; b++) begin
      merged[8*b +: 8] = mask_reg[{grp, 2'(b)}] ? pbuf[{grp, 2'(b)}] :
                         c.is_id ? idmem[{grp, 2'(b)}] : old_fix[8*b +: 8];
    end
  end

  // Read path returns corrected array byte, raw identification byte; transparent to the bus
  assign rbyte   = c.is_id ? idmem[c.addr[7:0]] : old_fix[8*c.addr[1:0] +: 8];
  assign walk_we = (c.st == S_WRITE) && (c.tw < TW_W'(PAGE_GRPS)) && !c.lock_req
                   && (|mask_reg[4*grp +: 4]);
  assign wr_ok   = !wc_f && !(c.is_id && locked);
  assign byte_wr = (c.st == S_WDAT) && scl_fall && (c.bits == 4'h8) && wr_ok
                   && !(c.is_id && c.addr[LOCK_ADDR_BIT]);

  always @(posedge ref_clk) begin
    if (walk_we) begin
      if (c.is_id) begin
        for (int b = 0; b < GRP_BYTES; b++) begin
          idmem[{grp, 2'(b)}] <= merged[8*b +: 8];
        end
      end else begin
        mem[rd_idx] <= {merged, ecc_check(merged)};
      end
    end
    if (c.st == S_WRITE && c.tw == TW_W'(TW_CYC - 1) && c.lock_req) begin
      locked <= 1'b1;
    end
    if (byte_wr) begin
      pbuf[c.addr[7:0]] <= c.sh;
    end
  end

  always_comb begin
    mask_next = mask_reg;
    if (c.st == S_ALO && scl_fall && c.bits == 4'h8) begin
      mask_next = '0;
    end
    if (byte_wr) begin
      mask_next[c.addr[7:0]] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      mask_reg <= '0;
    end else begin
      mask_reg <= mask_next;
    end
  end

  // ----------------------------------------------------------------
  // Bus state machine
  // ----------------------------------------------------------------
  always_comb begin
    n = c;
    if (!thr_f) begin
      n = '0;
      n.oe_n = 1'b1;
    end else if (c.st == S_WRITE) begin
      n.tw = c.tw + 1'b1;
      if (c.tw == TW_W'(TW_CYC - 1)) begin
        n.st = S_IDLE;
        n.pend = 1'b0;
        n.lock_req = 1'b0;
        n.tw = '0;
      end
    end else if (start_c) begin
      n.st = S_SEL;
      n.bits = '0;
      n.oe_n = 1'b1;
      n.pend = 1'b0;
      n.lock_req = 1'b0;
    end else if (stop_c) begin
      n.st = c.pend ? S_WRITE : S_IDLE;
      n.oe_n = 1'b1;
      n.tw = '0;
    end else begin
      unique case (c.st)
        S_SEL, S_AHI, S_ALO, S_WDAT: begin
          if (scl_rise && c.bits != 4'h8) begin
            n.sh = {c.sh[6:0], sda_f};
            n.bits = c.bits + 1'b1;
          end else if (scl_fall && c.bits == 4'h8) begin
            n.st = S_ACK;
            n.oe_n = 1'b0;
            n.bits = '0;
            n.after = S_WDAT;
            if (c.st == S_SEL) begin
              n.is_id = (c.sh[7:4] == TYPE_ID);
              n.after = c.sh[SEL_RW_BIT] ? S_RDAT : S_AHI;
              if (c.sh[7:4] == TYPE_MEM) begin
                n.addr[ADDR_W-1] = c.sh[SEL_A16_BIT];
              end
              if ((c.sh[7:4] != TYPE_MEM && c.sh[7:4] != TYPE_ID) || c.sh[3:2] != CHIP_ADDR) begin
                n.st = S_IDLE;
                n.oe_n = 1'b1;
              end
            end else if (c.st == S_AHI) begin
              n.addr[15:8] = c.sh;
              n.after = S_ALO;
            end else if (c.st == S_ALO) begin
              n.addr[7:0] = c.sh;
            end else begin
              n.oe_n = !wr_ok;
              if (wr_ok && c.is_id && c.addr[LOCK_ADDR_BIT]) begin
                n.lock_req = c.sh[LOCK_DATA_BIT];
                n.pend = c.sh[LOCK_DATA_BIT];
              end else if (wr_ok) begin
                n.pend = 1'b1;
                n.addr[7:0] = c.addr[7:0] + 1'b1;
              end
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            n.st = c.after;
            n.oe_n = 1'b1;
            if (c.after == S_RDAT) begin
              n.sh = rbyte;
              n.oe_n = rbyte[7];
            end
          end
        end
        S_RDAT: begin
          if (scl_fall) begin
            n.bits = c.bits + 1'b1;
            n.oe_n = c.sh[6];
            n.sh = {c.sh[6:0], 1'b1};
            if (c.bits == 4'h7) begin
              n.st = S_MACK;
              n.oe_n = 1'b1;
              n.bits = '0;
              if (c.is_id) begin
                n.addr[7:0] = c.addr[7:0] + 1'b1;
              end else begin
                n.addr = c.addr + 1'b1;
              end
            end
          end
        end
        S_MACK: begin
          if (scl_rise) begin
            n.st = sda_f ? S_IDLE : S_MACK;
            n.bits = 4'h8;
          end else if (scl_fall && c.bits == 4'h8) begin
            n.st = S_RDAT;
            n.bits = '0;
            n.sh = rbyte;
            n.oe_n = rbyte[7];
          end
        end
        S_IDLE: begin
          n.oe_n = 1'b1;
        end
        default: begin
          n.st = S_IDLE;
          n.oe_n = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      c <= '0;
      c.oe_n <= 1'b1;
    end else begin
      c <= n;
    end
  end

  assign sda_out  = 1'b0;
  assign sda_oe_n = c.oe_n;
  assign standby  = (c.st == S_IDLE);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_ignore_low_supply: assert property (!thr_f |=> c.st == S_IDLE && sda_oe_n)
    else $error("bus activity below threshold");
  a_por_standby: assert property ($rose(thr_f) |-> ##1 standby)
    else $error("not standby after threshold");
  a_ecc_one_bit: assert property ($countones(old_fix ^ mem[rd_idx].data) <= 1)
    else $error("correction flipped several bits");
  a_ecc_clean_pass: assert property (!ecc_err |-> old_fix == mem[rd_idx].data)
    else $error("clean word altered");
  a_group_merge: assert property (walk_we && !c.is_id && !mask_reg[{grp, 2'h0}]
    |-> merged[7:0] == old_fix[7:0])
    else $error("unwritten byte lost");
  a_write_start: assert property (thr_f && c.st != S_WRITE && stop_c && c.pend
    |=> c.st == S_WRITE && c.tw == '0)
    else $error("write cycle not started");
  a_write_end: assert property (c.st == S_WRITE && c.tw == TW_W'(TW_CYC - 1) && thr_f
    |=> standby && !c.pend)
    else $error("no deselect after write");
  a_busy_quiet: assert property (c.st == S_WRITE |-> sda_oe_n)
    else $error("bus driven during write");
  a_id_type: assert property (c.st == S_SEL && n.st == S_ACK && n.is_id
    |-> c.sh[7:4] == TYPE_ID)
    else $error("wrong device type for id page");

endmodule

// *** tb/i2c_master_bfm.sv ***
`timescale 1ns/1ps
module i2c_master_bfm (
  input  wire logic ref_clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_drv
);
  // ----------------------------------------------------------------
  // Bus idles released and high
  // ----------------------------------------------------------------
  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic w(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // ----------------------------------------------------------------
  // Framing, SCL left low after a start
  // ----------------------------------------------------------------
  task automatic start_c();
    sda_drv <= 1'b1;
    w(8);
    scl <= 1'b1;
    w(8);
    sda_drv <= 1'b0;
    w(8);
    scl <= 1'b0;
    w(8);
  endtask

  task automatic stop_c();
    sda_drv <= 1'b0;
    w(8);
    scl <= 1'b1;
    w(8);
    sda_drv <= 1'b1;
    w(8);
  endtask

  // ----------------------------------------------------------------
  // One bit, data settled well clear of both SCL edges
  // ----------------------------------------------------------------
  task automatic bit_x(input logic b, output logic r);
    sda_drv <= b;
    w(8);
    scl <= 1'b1;
    w(8);
    r = sda_line;
    w(8);
    scl <= 1'b0;
    w(8);
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, r);
    ack = ~r;
  endtask

  task automatic rd_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, d[i]);
    end
    bit_x(nack, r);
  endtask
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import eeprom_pkg::*;
  localparam int          TW     = 600;
  localparam logic [23:0] ID_VAL = 24'h9C4E21;  // Arbitrary identity value
  typedef logic [7:0] byte_arr_t [8];
  logic ref_clk;
  logic rstn;
  logic reset_threshold_level;
  logic write_ctrl;
  logic scl;
  logic sda_drv;
  logic sda_out;
  logic sda_oe_n;
  logic standby;
  wire  sda_line;
  int   fails;
  int   cmp_count;

  // Pull-up wire: low if either party pulls
  assign sda_line = sda_drv & (sda_oe_n | sda_out);

  eeprom_core #(.CHIP_ADDR(2'h0), .ID_CODE(ID_VAL), .TW_CYC(TW)) i_dut (
    .ref_clk(ref_clk), .rstn(rstn), .reset_threshold_level(reset_threshold_level),
    .write_ctrl(write_ctrl), .scl(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .standby(standby));
  i2c_master_bfm i_bus (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));

  initial ref_clk = 1'b0;
  always #20 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %02X seen %02X", name, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Transfer helpers
  // ----------------------------------------------------------------
  task automatic sel_addr(input logic [3:0] ty, input logic [16:0] a, output logic ok);
    logic k0, k1, k2;
    i_bus.start_c();
    i_bus.wr_byte({ty, 2'h0, a[16], 1'b0}, k0);
    i_bus.wr_byte(a[15:8], k1);
    i_bus.wr_byte(a[7:0], k2);
    ok = k0 & k1 & k2;
  endtask

  task automatic write_cycle(input string what);
    logic k;
    chk({what, " busy"}, {7'h0, standby}, 8'h00);
    i_bus.start_c();
    i_bus.wr_byte({TYPE_MEM, 4'h0}, k);
    i_bus.stop_c();
    chk({what, " poll"}, {7'h0, k}, 8'h00);
    i_bus.w(TW);
    chk({what, " done"}, {7'h0, standby}, 8'h01);
  endtask

  task automatic write_bytes(input logic [3:0] ty, input logic [16:0] a, input int n,
                             input byte_arr_t d, input logic ack_exp, input string what);
    logic ok;
    logic k;
    sel_addr(ty, a, ok);
    chk({what, " addr ack"}, {7'h0, ok}, 8'h01);
    for (int i = 0; i < n; i++) begin
      i_bus.wr_byte(d[i], k);
      chk({what, " data ack"}, {7'h0, k}, {7'h0, ack_exp});
    end
    if (ack_exp) begin
      i_bus.stop_c();
      write_cycle(what);
    end else begin
      i_bus.start_c();
      i_bus.stop_c();
    end
  endtask

  task automatic read_bytes(input logic [3:0] ty, input logic [16:0] a, input int n,
                            input byte_arr_t e, input string what);
    logic ok;
    logic k;
    logic [7:0] v;
    sel_addr(ty, a, ok);
    i_bus.start_c();
    i_bus.wr_byte({ty, 2'h0, a[16], 1'b1}, k);
    chk({what, " select"}, {7'h0, ok & k}, 8'h01);
    for (int i = 0; i < n; i++) begin
      i_bus.rd_byte(i == n - 1, v);
      chk(what, v, e[i]);
    end
    i_bus.stop_c();
    chk({what, " deselect"}, {7'h0, standby}, 8'h01);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_power();
    logic ok;
    sel_addr(TYPE_MEM, 17'h00000, ok);
    i_bus.stop_c();
    chk("below threshold", {7'h0, ok}, 8'h00);
    reset_threshold_level <= 1'b1;
    i_bus.w(10);
    chk("standby at threshold", {7'h0, standby}, 8'h01);
    chk("released at threshold", {7'h0, sda_oe_n}, 8'h01);
    $display("Test power done");
  endtask

  task automatic t_array();
    byte_arr_t d;
    byte_arr_t e;
    d = '{default: 8'h00};
    e = '{default: ERASED_BYTE};
    read_bytes(TYPE_MEM, 17'h1FFFC, 8, e, "delivered wrap");
    d[0] = 8'h5A;
    write_bytes(TYPE_MEM, 17'h10105, 1, d, 1'b1, "byte write");
    e[1] = 8'h5A;
    read_bytes(TYPE_MEM, 17'h10104, 4, e, "group after byte");
    d[0] = 8'h3C;
    write_bytes(TYPE_MEM, 17'h10106, 1, d, 1'b1, "merge write");
    e = '{default: ERASED_BYTE};
    e[5] = 8'h5A;
    e[6] = 8'h3C;
    read_bytes(TYPE_MEM, 17'h10100, 8, e, "groups merged");
    e = '{default: ERASED_BYTE};
    e[1] = 8'h5A;
    e[2] = 8'h3C;
    // Flip one stored data bit of the group at 10104h
    i_dut.mem[15'h4041] = i_dut.mem[15'h4041] ^ 38'h0000004000;
    read_bytes(TYPE_MEM, 17'h10104, 4, e, "single bit fixed");
    d[0] = 8'h81;
    write_bytes(TYPE_MEM, 17'h10107, 1, d, 1'b1, "write over fault");
    e[3] = 8'h81;
    read_bytes(TYPE_MEM, 17'h10104, 4, e, "fault merged");
    $display("Test array done");
  endtask

  task automatic t_page();
    byte_arr_t d;
    byte_arr_t e;
    d = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h00, 8'h00, 8'h00, 8'h00};
    write_bytes(TYPE_MEM, 17'h00206, 4, d, 1'b1, "page write");
    e = '{8'hFF, 8'hFF, 8'h11, 8'h22, 8'h33, 8'h44, 8'hFF, 8'hFF};
    read_bytes(TYPE_MEM, 17'h00204, 8, e, "page groups");
    write_ctrl <= 1'b1;
    i_bus.w(4);
    write_bytes(TYPE_MEM, 17'h00207, 1, d, 1'b0, "inhibited");
    write_ctrl <= 1'b0;
    i_bus.w(4);
    read_bytes(TYPE_MEM, 17'h00204, 4, e, "kept");
    $display("Test page done");
  endtask

  task automatic t_ident();
    byte_arr_t d;
    byte_arr_t e;
    d = '{default: 8'h00};
    e = '{default: ERASED_BYTE};
    e[0] = ID_VAL[23:16];
    e[1] = ID_VAL[15:8];
    e[2] = ID_VAL[7:0];
    read_bytes(TYPE_ID, 17'h00000, 3, e, "identity");
    d[0] = 8'h77;
    write_bytes(TYPE_ID, 17'h00205, 1, d, 1'b1, "id write");
    e = '{default: ERASED_BYTE};
    e[1] = 8'h77;
    read_bytes(TYPE_ID, 17'h00004, 4, e, "id readback");
    read_bytes(TYPE_MEM, 17'h00205, 1, e, "array apart");
    d[0] = 8'h02;
    write_bytes(TYPE_ID, 17'h00400, 1, d, 1'b1, "lock");
    write_bytes(TYPE_ID, 17'h00006, 1, d, 1'b0, "locked write");
    $display("Test ident done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    rstn                  = 1'b0;
    reset_threshold_level = 1'b0;
    write_ctrl            = 1'b0;
    fails                 = 0;
    cmp_count             = 0;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    i_bus.w(8);
    t_power();
    t_array();
    t_page();
    t_ident();
    close_out();
  end

  initial begin
    repeat (80000) @(posedge ref_clk);
    fails++;
    $display("[ERR] watchdog expected done seen hang");
    close_out();
  end
endmodule
